// File: tb_timeslot_switch_ctrl_regs.sv
`timescale 1ns/1ps
`include "tsc_params.svh"

module tb_timeslot_switch_ctrl_regs
    import tsc_pkg::*;
;
    localparam tsc_byte_t VER = 8'h3C; // arbitrary value
    logic       mclk, rst, host_wr, host_rd, clock_failure_line, frame_sync_event;
    logic [1:0] host_sel;
    tsc_byte_t  host_wdata, host_rdata, v;
    logic       bus_bit_clock, double_rate_bus_clock_n, ingress_data, ingress_clock;
    logic       ingress_frame_sync, ingress_multiframe_sync, alt_ingress_clock_n;
    logic       alt_frame_pulse_n, alt_multiframe_pulse_n, left_transmit_stream;
    logic       left_slot_enable_n, alt_transmit_stream, egress_clock, egress_slot_active;
    logic       msg_tx_data, sample_valid, sample_bit, local_in_clock, local_in_frame;
    logic       local_in_mframe, exp_open_collector, egress_data_out, egress_data_oe;
    logic       message_channel_line_out, message_channel_line_oe, int_out, int_oe;
    int         n_errors, checks_done;

    tsc_regs #(.VERSION_ID(VER)) u_dut (
        .mclk, .rst, .host_sel, .host_wdata, .host_wr, .host_rd, .host_rdata,
        .clock_failure_line, .frame_sync_event, .bus_bit_clock, .double_rate_bus_clock_n,
        .ingress_data, .ingress_clock, .ingress_frame_sync, .ingress_multiframe_sync,
        .alt_ingress_clock_n, .alt_frame_pulse_n, .alt_multiframe_pulse_n,
        .left_transmit_stream, .left_slot_enable_n, .alt_transmit_stream, .egress_clock,
        .egress_slot_active, .msg_tx_data, .sample_valid, .sample_bit, .local_in_clock,
        .local_in_frame, .local_in_mframe, .exp_open_collector, .egress_data_out,
        .egress_data_oe, .message_channel_line_out, .message_channel_line_oe, .int_out,
        .int_oe
    );

    tsc_bus_env u_env (.bus_bit_clock, .double_rate_bus_clock_n, .ingress_data);

    always #12.5 mclk = ~mclk;

    // ********
    // host access and checking
    // ********
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task host_write(input tsc_sel_e s, input tsc_byte_t d);
        @(posedge mclk);
        host_sel   <= s;
        host_wdata <= d;
        host_wr    <= 1'b1;
        @(posedge mclk);
        host_wr    <= 1'b0;
        host_sel   <= TSC_SEL_NONE;
    endtask : host_write

    // two idle cycles let the registered memory read catch up with the pointer
    task host_read(input tsc_sel_e s, output tsc_byte_t d);
        repeat (2) @(posedge mclk);
        host_sel <= s;
        host_rd  <= 1'b1;
        @(posedge mclk);
        host_rd  <= 1'b0;
        host_sel <= TSC_SEL_NONE;
        @(posedge mclk);
        @(negedge mclk);
        d = host_rdata;
    endtask : host_read

    task peek(input tsc_byte_t ofs, input tsc_sel_e s, input tsc_byte_t exp);
        host_write(TSC_SEL_PTR, ofs);
        host_read(s, v);
        chk($sformatf("reg %h sel %0d", ofs, s), v, exp);
    endtask : peek

    task setcfg(input tsc_byte_t c1, input tsc_byte_t c3, input tsc_byte_t c4);
        host_write(TSC_SEL_PTR, `TSC_OFS_CFG1);
        host_write(TSC_SEL_LOW, c1);
        host_write(TSC_SEL_PTR, `TSC_OFS_CFG3);
        host_write(TSC_SEL_LOW, c3);
        host_write(TSC_SEL_PTR, `TSC_OFS_CFG4);
        host_write(TSC_SEL_LOW, c4);
    endtask : setcfg

    // async pins pass a synchroniser, so give them a few cycles
    task settle;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    task mode_chk(input tsc_byte_t c1, input tsc_byte_t c3, input logic oc, input logic fr,
                  input logic ms, input logic ec, input logic mo);
        setcfg(c1, c3, 8'h00);
        msg_tx_data  <= ms;
        egress_clock <= ec;
        settle;
        chk("exp_open_collector", {7'h0, exp_open_collector}, {7'h0, oc});
        chk("local_in", {5'h0, local_in_clock, local_in_frame, local_in_mframe}, {5'h0, {3{fr}}});
        chk("message_channel", {6'h0, message_channel_line_oe, message_channel_line_out},
            {6'h0, mo, 1'b0});
    endtask : mode_chk

    task egress(input tsc_byte_t c3, input logic sen_n, input logic exp);
        setcfg(8'h50, c3, 8'h00);
        left_slot_enable_n <= sen_n;
        settle;
        chk("egress_data", {6'h0, egress_data_oe, egress_data_out}, {6'h0, 1'b1, exp});
    endtask : egress

    // the first pulses may still carry the old sample point
    task samp(input tsc_byte_t c1, input tsc_byte_t c3, input logic late);
        int k;
        setcfg(c1, c3, 8'h00);
        repeat (3)
        begin
            k = 0;
            @(negedge mclk);
            while (sample_valid !== 1'b1 && k < 100)
            begin
                @(negedge mclk);
                k++;
            end
        end
        chk("sample_valid", {7'h0, sample_valid}, 8'h01);
        chk("sample_bit", {7'h0, sample_bit}, {7'h0, late ? ingress_data : ~ingress_data});
    endtask : samp

    task results;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // ********
    // tests
    // ********
    initial
    begin
        {mclk, host_wr, host_rd, frame_sync_event, ingress_clock, ingress_frame_sync} = '0;
        {ingress_multiframe_sync, alt_ingress_clock_n, alt_frame_pulse_n} = '0;
        {alt_multiframe_pulse_n, left_transmit_stream, egress_clock} = '0;
        {egress_slot_active, msg_tx_data, left_slot_enable_n} = '0;
        {alt_transmit_stream, clock_failure_line, rst} = 3'h7;
        host_sel   = TSC_SEL_NONE;
        host_wdata = 8'h00;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        peek(`TSC_OFS_CFG3, TSC_SEL_LOW, 8'h00);
        peek(`TSC_OFS_CFG4, TSC_SEL_LOW, 8'h00);
        peek(`TSC_OFS_VER, TSC_SEL_LOW, VER);
        host_write(TSC_SEL_LOW, 8'hFF);
        peek(`TSC_OFS_VER, TSC_SEL_LOW, VER);
        for (int i = 0; i < 32; i++)
        begin
            peek(8'h80 + i[7:0], TSC_SEL_LOW, 8'h00);
            peek(8'h80 + i[7:0], TSC_SEL_HIGH, 8'h00);
        end
        host_write(TSC_SEL_PTR, 8'h80);
        host_write(TSC_SEL_LOW, 8'hFF);
        host_write(TSC_SEL_HIGH, 8'hFF);
        host_write(TSC_SEL_PTR, 8'h9F);
        host_write(TSC_SEL_LOW, 8'h2A);
        host_write(TSC_SEL_HIGH, 8'h05);
        host_write(TSC_SEL_PTR, 8'hA0);
        host_write(TSC_SEL_LOW, 8'h11);
        host_write(TSC_SEL_HIGH, 8'h03);
        host_write(TSC_SEL_PTR, 8'h81);
        host_write(TSC_SEL_LOW, 8'h33);
        peek(8'h80, TSC_SEL_LOW, 8'h7F);
        peek(8'h80, TSC_SEL_HIGH, 8'h0F);
        peek(8'h9F, TSC_SEL_LOW, 8'h2A);
        peek(8'h9F, TSC_SEL_HIGH, 8'h05);
        peek(8'hA0, TSC_SEL_HIGH, 8'h00);
        peek(8'h81, TSC_SEL_LOW, 8'h00);
        peek(8'h01, TSC_SEL_LOW, 8'h00);
        setcfg(8'h00, 8'hFE, 8'h00);
        peek(`TSC_OFS_CFG3, TSC_SEL_LOW, 8'hFE);
        mode_chk(8'h00, 8'h14, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        mode_chk(8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        mode_chk(8'h10, 8'h14, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        mode_chk(8'h00, 8'h20, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        mode_chk(8'h00, 8'h20, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        egress(8'h00, 1'b0, 1'b0);
        egress(8'h40, 1'b0, 1'b1);
        egress(8'h40, 1'b1, 1'b0);
        samp(8'h00, 8'h00, 1'b0);
        samp(8'h00, 8'h02, 1'b1);
        samp(8'h10, 8'h02, 1'b0);
        setcfg(8'h00, 8'h00, 8'hD0);
        host_write(TSC_SEL_LOW, 8'hFC);
        settle;
        chk("int pair", {6'h0, int_oe, int_out}, 8'h03);
        peek(`TSC_OFS_CFG4, TSC_SEL_LOW, 8'hFD);
        host_write(TSC_SEL_LOW, 8'hDC);
        settle;
        chk("int pair", {6'h0, int_oe, int_out}, 8'h02);
        @(posedge mclk);
        frame_sync_event <= 1'b1;
        peek(`TSC_OFS_CFG4, TSC_SEL_LOW, 8'hDF);
        @(posedge mclk);
        frame_sync_event <= 1'b0;
        host_write(TSC_SEL_PTR, `TSC_OFS_CFG1);
        host_write(TSC_SEL_LOW, 8'h10);
        peek(`TSC_OFS_CFG4, TSC_SEL_LOW, 8'hDC);
        host_write(TSC_SEL_PTR, `TSC_OFS_CFG1);
        host_write(TSC_SEL_LOW, 8'h90);
        peek(`TSC_OFS_CFG4, TSC_SEL_LOW, 8'hDE);
        host_write(TSC_SEL_PTR, `TSC_OFS_CFG1);
        host_write(TSC_SEL_LOW, 8'h00);
        host_write(TSC_SEL_PTR, `TSC_OFS_CFG4);
        host_write(TSC_SEL_LOW, 8'hD8);
        peek(`TSC_OFS_CFG4, TSC_SEL_LOW, 8'hDA);
        host_write(TSC_SEL_LOW, 8'hD0);
        peek(`TSC_OFS_CFG4, TSC_SEL_LOW, 8'hD0);
        host_write(TSC_SEL_LOW, 8'h3C);
        settle;
        chk("int pair", {6'h0, int_oe, int_out}, 8'h02);
        host_write(TSC_SEL_LOW, 8'h38);
        settle;
        chk("int pair", {6'h0, int_oe, int_out}, 8'h00);
        host_write(TSC_SEL_LOW, 8'h28);
        host_write(TSC_SEL_LOW, 8'h2C);
        peek(`TSC_OFS_CFG4, TSC_SEL_LOW, 8'h2C);
        @(posedge mclk);
        clock_failure_line <= 1'b0;
        peek(`TSC_OFS_CFG4, TSC_SEL_LOW, 8'h2D);
        results;
    end

    initial
    begin
        #500000;
        n_errors++;
        results;
    end
endmodule : tb_timeslot_switch_ctrl_regs

// File: tsc_bus_env.sv
`timescale 1ns/1ps

// ********
// expansion bus timing seen from the local side
// ********
module tsc_bus_env (
    output logic bus_bit_clock,
    output logic double_rate_bus_clock_n,
    output logic ingress_data
);
    initial ingress_data = 1'b0;

    // data moves at 60% of the cell, so the mid and late sample points disagree
    always
    begin
        bus_bit_clock = 1'b1;
        double_rate_bus_clock_n = 1'b0;
        #50;
        double_rate_bus_clock_n = 1'b1;
        #50;
        bus_bit_clock = 1'b0;
        double_rate_bus_clock_n = 1'b0;
        #20;
        ingress_data = ~ingress_data;
        #30;
        double_rate_bus_clock_n = 1'b1;
        #50;
    end
endmodule : tsc_bus_env

// File: tsc_params.svh
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

// ****************************************
// internal register offsets
// ****************************************
`define TSC_OFS_CFG1      8'h00
`define TSC_OFS_CFG3      8'h02
`define TSC_OFS_CFG4      8'h03
`define TSC_OFS_VER       8'h04
`define TSC_OFS_RT_FIRST  8'h80
`define TSC_OFS_RT_LAST   8'h9F

// ****************************************
// field positions and widths
// ****************************************
`define TSC_C1_BUSSEL     4
`define TSC_C1_TYPE0      6
`define TSC_C1_TYPE1      7
`define TSC_C3_LSAMPLE    1
`define TSC_C3_EXPDRV     2
`define TSC_C3_SODRV      3
`define TSC_C3_LFRAME     4
`define TSC_C3_MSGSEL     5
`define TSC_C3_MUX_LO     6
`define TSC_C3_MUX_HI     7
`define TSC_C4_CF         0
`define TSC_C4_FS         1
`define TSC_C4_CFCLR_N    2
`define TSC_C4_FSCLR_N    3
`define TSC_C4_CFPOL      4
`define TSC_C4_MASK_N     5
`define TSC_C4_IPOL       6
`define TSC_C4_IDRV       7
`define TSC_RT_TS_W       7
`define TSC_RT_ST_W       4

// ****************************************
// reset values and codes
// ****************************************
`define TSC_CFG_RST       8'h00
`define TSC_PTR_RST       8'h00
`define TSC_MUX_LEFT      2'h0
`define TSC_MUX_SLOT      2'h1

`endif

// File: tsc_pkg.sv
package tsc_pkg;

    // host port register select
    typedef enum logic [1:0]
    {
        TSC_SEL_PTR  = 2'b00,
        TSC_SEL_LOW  = 2'b01,
        TSC_SEL_HIGH = 2'b10,
        TSC_SEL_NONE = 2'b11
    } tsc_sel_e;

    typedef logic [7:0] tsc_byte_t;

endpackage : tsc_pkg

// File: tsc_regs.sv
`timescale 1ns/1ps
`include "tsc_params.svh"

// Function
// (RULE_01) local sample point: mid or three quarters
// (RULE_02) late sample needs double-rate bus clock
// (RULE_03) expansion driver: tri-state or open collector
// (RULE_04) egress driver type; legacy non-switching always enabled
// (RULE_05) inverted-sync framing swaps ingress timing inputs
// (RULE_06) inverted framing needs fast enough clock
// (RULE_07) message transmit: transparent or latched buffer
// (RULE_08) controller changes data on matching edge
// (RULE_09) mux field picks egress data source
// (RULE_10) clock-failure status reads latch, shared only
// (RULE_11) frame-sync status cleared in non-switching mode
// (RULE_12) clock-failure clear bit clears, disables interrupt
// (RULE_13) frame-sync clear bit clears, disables interrupt
// (RULE_14) polarity picks level setting clock-failure latch
// (RULE_15) change polarity only while interrupt disabled
// (RULE_16) interrupt is masked OR of latches
// (RULE_17) interrupt polarity bit selects active level
// (RULE_18) interrupt driver: open collector or totem-pole
// (RULE_19) read-only version and revision register
// (RULE_20) routing memory at 80H through 9FH
// (RULE_21) entry holds slot number and stream number
// (RULE_22) reset clears all routing entries
// (RULE_23) bus select bit: shared or legacy mode
// (RULE_24) legacy module type field encoding
module tsc_regs
    import tsc_pkg::*;
#(
    parameter logic [7:0] VERSION_ID = 8'hA5 // arbitrary value
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [1:0] host_sel,
    input  wire logic [7:0] host_wdata,
    input  wire logic       host_wr,
    input  wire logic       host_rd,
    output logic      [7:0] host_rdata,
    input  wire logic       clock_failure_line,
    input  wire logic       frame_sync_event,
    input  wire logic       bus_bit_clock,
    input  wire logic       double_rate_bus_clock_n,
    input  wire logic       ingress_data,
    input  wire logic       ingress_clock,
    input  wire logic       ingress_frame_sync,
    input  wire logic       ingress_multiframe_sync,
    input  wire logic       alt_ingress_clock_n,
    input  wire logic       alt_frame_pulse_n,
    input  wire logic       alt_multiframe_pulse_n,
    input  wire logic       left_transmit_stream,
    input  wire logic       left_slot_enable_n,
    input  wire logic       alt_transmit_stream,
    input  wire logic       egress_clock,
    input  wire logic       egress_slot_active,
    input  wire logic       msg_tx_data,
    output logic            sample_valid,
    output logic            sample_bit,
    output logic            local_in_clock,
    output logic            local_in_frame,
    output logic            local_in_mframe,
    output logic            exp_open_collector,
    output logic            egress_data_out,
    output logic            egress_data_oe,
    output logic            message_channel_line_out,
    output logic            message_channel_line_oe,
    output logic            int_out,
    output logic            int_oe
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int NS = 17;

    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    wire  [NS-1:0] pins = {msg_tx_data, egress_slot_active, egress_clock,
                           alt_transmit_stream, left_slot_enable_n,
                           left_transmit_stream, alt_multiframe_pulse_n,
                           alt_frame_pulse_n, alt_ingress_clock_n,
                           ingress_multiframe_sync, ingress_frame_sync,
                           ingress_clock, ingress_data,
                           double_rate_bus_clock_n, bus_bit_clock,
                           frame_sync_event, clock_failure_line};

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s1 <= '0;
            s2 <= '0;
        end
        else
        begin
            s1 <= pins;
            s2 <= s1;
        end
    end

    wire cf_line  = s2[0];
    wire fs_line  = s2[1];
    wire bclk     = s2[2];
    wire dclk     = s2[3];
    wire in_data  = s2[4];
    wire in_clk   = s2[5];
    wire in_fs    = s2[6];
    wire in_ms    = s2[7];
    wire alt_clk  = s2[8];
    wire alt_fs   = s2[9];
    wire alt_ms   = s2[10];
    wire l_stream = s2[11];
    wire l_en_n   = s2[12];
    wire a_stream = s2[13];
    wire eclk     = s2[14];
    wire eg_act   = s2[15];
    wire msg_in   = s2[16];

    // ****************************************
    // host registers
    // ****************************************
    logic [7:0] ptr;
    logic [7:0] cfg1;
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    logic [6:0] low_hold;
    logic       cf_latch;
    logic       fs_latch;

    wire legacy   = cfg1[`TSC_C1_BUSSEL];   // see RULE_23
    wire net_mod  = cfg1[`TSC_C1_TYPE0];    // see RULE_24
    wire sw_mod   = cfg1[`TSC_C1_TYPE1];
    wire cf_clr_n = cfg4[`TSC_C4_CFCLR_N];
    wire fs_clr_n = cfg4[`TSC_C4_FSCLR_N];
    wire mask_n   = cfg4[`TSC_C4_MASK_N];
    wire ipol     = cfg4[`TSC_C4_IPOL];
    wire idrv     = cfg4[`TSC_C4_IDRV];

    wire wr_ptr   = host_wr && (host_sel == TSC_SEL_PTR);
    wire wr_low   = host_wr && (host_sel == TSC_SEL_LOW);
    wire wr_high  = host_wr && (host_sel == TSC_SEL_HIGH);
    wire in_route = (ptr >= `TSC_OFS_RT_FIRST) && (ptr <= `TSC_OFS_RT_LAST); // see RULE_20

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ptr      <= `TSC_PTR_RST;
            cfg1     <= `TSC_CFG_RST;
            cfg3     <= `TSC_CFG_RST;
            cfg4     <= `TSC_CFG_RST;
            low_hold <= '0;
        end
        else
        begin
            if (wr_ptr)
            begin
                ptr <= host_wdata;
            end
            if (wr_low)
            begin
                low_hold <= host_wdata[6:0];
            end
            if (wr_low && ptr == `TSC_OFS_CFG1)
            begin
                cfg1 <= host_wdata & 8'hD0;
            end
            if (wr_low && ptr == `TSC_OFS_CFG3)
            begin
                cfg3 <= host_wdata;
            end
            // latch status bits are read-only, never stored
            if (wr_low && ptr == `TSC_OFS_CFG4)
            begin
                cfg4 <= host_wdata & 8'hFC;
            end
        end
    end

    // ****************************************
    // routing memory
    // ****************************************
    logic [10:0] rt_q;

    // entry is committed by the high byte write, low byte held from before
    tsc_route_mem #(
        .AW (5),
        .DW (11)
    ) u_route (
        .clk   (mclk),
        .rst   (rst),
        .we    (wr_high && in_route),
        .waddr (ptr[4:0]),
        .wdata ({host_wdata[`TSC_RT_ST_W-1:0], low_hold}), // see RULE_21
        .raddr (ptr[4:0]),
        .rdata (rt_q)
    );

    // ****************************************
    // latches and interrupt
    // ****************************************
    logic fs_d;

    wire cf_set     = cf_clr_n && (cf_line == cfg4[`TSC_C4_CFPOL]); // see RULE_14
    wire fs_set     = fs_clr_n && fs_line && !fs_d;
    wire irq_active = mask_n && (cf_latch || fs_latch);           // see RULE_16
    wire int_level  = ipol ? irq_active : !irq_active;            // see RULE_17

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cf_latch <= 1'b0;
            fs_latch <= 1'b0;
            fs_d     <= 1'b0;
            int_out  <= 1'b0;
            int_oe   <= 1'b0;
        end
        else
        begin
            fs_d     <= fs_line;
            cf_latch <= cf_clr_n && (cf_latch || cf_set); // see RULE_12
            fs_latch <= fs_clr_n && (fs_latch || fs_set); // see RULE_13
            // open collector only pulls low; totem drives both levels
            int_out  <= idrv && int_level;                // see RULE_18
            int_oe   <= idrv || !int_level;
        end
    end

    // ****************************************
    // host read path
    // ****************************************
    wire cf_rd = !legacy && cf_latch;                     // see RULE_10
    wire fs_rd = (!legacy || sw_mod) && fs_latch;         // see RULE_11

    logic [7:0] rd_low;

    always_comb
    begin
        case (ptr)
            `TSC_OFS_CFG1: rd_low = cfg1;
            `TSC_OFS_CFG3: rd_low = cfg3;
            `TSC_OFS_CFG4: rd_low = {cfg4[7:2], fs_rd, cf_rd};
            `TSC_OFS_VER:  rd_low = VERSION_ID;           // see RULE_19
            default:       rd_low = in_route ? {1'b0, rt_q[6:0]} : 8'h00;
        endcase
    end

    wire [7:0] rd_high = in_route ? {4'h0, rt_q[10:7]} : 8'h00;
    wire [7:0] rd_mux  = (host_sel == TSC_SEL_PTR)  ? ptr :
                         (host_sel == TSC_SEL_LOW)  ? rd_low :
                         (host_sel == TSC_SEL_HIGH) ? rd_high : 8'h00;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            host_rdata <= 8'h00;
        end
        else if (host_rd)
        begin
            host_rdata <= rd_mux;
        end
    end

    // ****************************************
    // local bus sampling and framing
    // ****************************************
    logic bclk_d;
    logic dclk_d;
    logic late_arm;

    wire sample_late = !legacy && cfg3[`TSC_C3_LSAMPLE]; // see RULE_01
    wire bus_fall    = bclk_d && !bclk;
    // late point waits for the double-rate clock; absent, no sample occurs
    wire dclk_rise   = !dclk_d && dclk;                  // see RULE_02
    wire strobe      = (bus_fall && !sample_late) || (late_arm && dclk_rise);
    wire inv_frame   = !legacy && cfg3[`TSC_C3_LFRAME];  // see RULE_05

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            bclk_d          <= 1'b0;
            dclk_d          <= 1'b0;
            late_arm        <= 1'b0;
            sample_valid    <= 1'b0;
            sample_bit      <= 1'b0;
            local_in_clock  <= 1'b0;
            local_in_frame  <= 1'b0;
            local_in_mframe <= 1'b0;
        end
        else
        begin
            bclk_d          <= bclk;
            dclk_d          <= dclk;
            late_arm        <= sample_late && (bus_fall || (late_arm && !dclk_rise));
            sample_valid    <= strobe;
            sample_bit      <= strobe ? in_data : sample_bit;
            local_in_clock  <= inv_frame ? !alt_clk : in_clk;
            local_in_frame  <= inv_frame ? !alt_fs : in_fs;
            local_in_mframe <= inv_frame ? !alt_ms : in_ms;
        end
    end

    // ****************************************
    // egress stream and message channel
    // ****************************************
    logic eclk_d;
    logic msg_hold;

    wire [1:0] mux_sel = cfg3[`TSC_C3_MUX_HI:`TSC_C3_MUX_LO];
    wire use_slot  = legacy && net_mod && (mux_sel == `TSC_MUX_SLOT); // see RULE_09
    wire eg_src    = (use_slot && !l_en_n) ? a_stream : l_stream;
    wire eg_always = legacy && !sw_mod;                               // see RULE_04
    wire so_oc     = cfg3[`TSC_C3_SODRV];
    wire next_eg_oe  = eg_always || (eg_act && (!so_oc || !eg_src));
    wire next_eg_out = (eg_always || !so_oc) && eg_src;
    wire msg_bit   = cfg3[`TSC_C3_MSGSEL] ? msg_hold : msg_in;        // see RULE_07

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            eclk_d                   <= 1'b0;
            msg_hold                 <= 1'b0;
            egress_data_out          <= 1'b0;
            egress_data_oe           <= 1'b0;
            exp_open_collector       <= 1'b0;
            message_channel_line_out <= 1'b0;
            message_channel_line_oe  <= 1'b0;
        end
        else
        begin
            eclk_d <= eclk;
            // latched mode takes data at the egress clock rise, clear of the fall launch
            if (!eclk_d && eclk)
            begin
                msg_hold <= msg_in;                                    // see RULE_08
            end
            egress_data_out          <= next_eg_out;
            egress_data_oe           <= next_eg_oe;
            exp_open_collector       <= legacy || cfg3[`TSC_C3_EXPDRV]; // see RULE_03
            message_channel_line_out <= 1'b0;
            message_channel_line_oe  <= !legacy && !msg_bit;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_late_shared;
        legacy ##1 legacy |-> !sample_late && !late_arm;
    endproperty
    a_late_shared: assert property (p_late_shared) // see RULE_01
        else $error("late sample armed in legacy mode");

    property p_exp_oc;
        legacy ##1 legacy |-> exp_open_collector;
    endproperty
    a_exp_oc: assert property (p_exp_oc) // see RULE_03
        else $error("expansion driver not open collector in legacy mode");

    property p_egress_on;
        eg_always ##1 eg_always |-> egress_data_oe;
    endproperty
    a_egress_on: assert property (p_egress_on) // see RULE_04
        else $error("egress not enabled in non-switching mode");

    property p_msg_off;
        legacy ##1 legacy |-> !message_channel_line_oe;
    endproperty
    a_msg_off: assert property (p_msg_off) // see RULE_07
        else $error("message channel driven in legacy mode");

    property p_cf_read;
        host_rd && host_sel == TSC_SEL_LOW && ptr == `TSC_OFS_CFG4 && legacy
            |=> !host_rdata[0];
    endproperty
    a_cf_read: assert property (p_cf_read) // see RULE_10
        else $error("clock-failure status read set in legacy mode");

    property p_fs_read;
        host_rd && host_sel == TSC_SEL_LOW && ptr == `TSC_OFS_CFG4 && fs_latch
            && (!legacy || sw_mod) |=> host_rdata[1];
    endproperty
    a_fs_read: assert property (p_fs_read) // see RULE_11
        else $error("frame-sync status lost");

    property p_cf_clear;
        !cf_clr_n |=> !cf_latch;
    endproperty
    a_cf_clear: assert property (p_cf_clear) // see RULE_12
        else $error("clock-failure latch set while cleared");

    property p_fs_clear;
        !fs_clr_n |=> !fs_latch;
    endproperty
    a_fs_clear: assert property (p_fs_clear) // see RULE_13
        else $error("frame-sync latch set while cleared");

    property p_int_high;
        irq_active && ipol && idrv |=> int_out && int_oe;
    endproperty
    a_int_high: assert property (p_int_high) // see RULE_17
        else $error("active-high totem interrupt not driven high");

    property p_int_mask;
        !mask_n && !ipol |=> int_oe == $past(idrv);
    endproperty
    a_int_mask: assert property (p_int_mask) // see RULE_16
        else $error("masked interrupt asserted");

    property p_version;
        host_rd && host_sel == TSC_SEL_LOW && ptr == `TSC_OFS_VER
            |=> host_rdata == VERSION_ID;
    endproperty
    a_version: assert property (p_version) // see RULE_19
        else $error("version register read wrong");

    c_late_sample: cover property (sample_late ##[1:40] sample_valid);
    c_cf_irq:      cover property (cf_latch && mask_n ##1 int_oe);
    c_route_write: cover property (wr_high && in_route);
    c_slot_mux:    cover property (use_slot && !l_en_n);

endmodule : tsc_regs

// File: tsc_route_mem.sv
`timescale 1ns/1ps

module tsc_route_mem #(
    parameter int AW = 5,
    parameter int DW = 11
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];

    // every entry clears at reset, so no stale route survives a restart
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 2**AW; i++)
            begin
                mem[i] <= '0; // see RULE_22
            end
            rdata <= '0;
        end
        else
        begin
            if (we)
            begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end

endmodule : tsc_route_mem
